// ---- bench/biu_zone_model.sv ----
// far-side model of the flash and io zone memories
`timescale 1ns/100ps
module biu_zone_model (
   input  wire logic        clock,
   input  wire logic [23:0] bus_addr,
   input  wire logic [15:0] bus_wdata,
   input  wire logic        bus_rd,
   input  wire logic        bus_data_oe,
   input  wire logic [3:0]  slow,
   output logic [15:0]      bus_rdata,
   output logic [15:0]      wr_data,
   output logic [7:0]       oe_cycles,
   output logic             wr_bad
);
   logic [3:0]  rd_age = 4'h0;
   logic [7:0]  oe_run = 8'h0;
   logic [15:0] junk   = 16'hC33C;
   logic        bad_q  = 1'b0;
   logic [7:0]  oe_q   = 8'h0;
   // flags are owned by the clocked process alone, outputs only follow
   assign wr_bad    = bad_q;
   assign oe_cycles = oe_q;
   // =====================================================
   // read side: age of the current read, junk changes every clock
   always_ff @(posedge clock) begin
      rd_age <= bus_rd ? rd_age + 4'h1 : 4'h0;
      junk   <= ~junk;
   end
   // data shows only once the read has lasted slow clocks
   assign bus_rdata = (bus_rd && rd_age >= slow) ?
                      (bus_addr[15:0] ^ 16'h5A3C) : junk;
   // =====================================================
   // write side: length of the driven phase, data must not move
   always_ff @(posedge clock) begin
      if (bus_data_oe) begin
         oe_run  <= oe_run + 8'h1;
         wr_data <= bus_wdata;
         if (oe_run != 8'h0 && bus_wdata !== wr_data)
            bad_q <= 1'b1;
      end else if (oe_run != 8'h0) begin
         oe_q   <= oe_run;
         oe_run    <= 8'h0;
      end
   end
endmodule

// ---- bench/test_bus_interface_unit_config.sv ----
// self-checking bench for the bus interface unit
`timescale 1ns/100ps
module test_bus_interface_unit_config;
   import biu_pkg::*;
   logic        clock, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [2:0]  boot_config_pins, boot_pins_driven;
   logic        flash_empty, internal_code_mode, external_code_mode;
   logic        offchip_program_mode, in_system_programming_mode;
   logic [25:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic        req_valid, req_write, req_done, err;
   logic [23:0] req_addr, bus_addr;
   logic [15:0] req_wdata, req_rdata, bus_wdata, bus_rdata, wr_data;
   logic        bus_rd, bus_wr, bus_data_oe, bus_wide, bus_external;
   logic        wr_bad;
   logic [3:0]  slow;
   logic [7:0]  oe_cycles;
   int          fail_count, n_tests, cycles;

   biu_top DUT (.clock, .rst_n, .boot_config_pins, .boot_pins_driven,
      .flash_empty, .internal_code_mode, .external_code_mode,
      .offchip_program_mode, .in_system_programming_mode, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .req_valid, .req_write, .req_addr, .req_wdata, .req_done,
      .req_rdata, .bus_addr, .bus_wdata, .bus_rd, .bus_wr, .bus_data_oe,
      .bus_wide, .bus_external, .bus_rdata);
   biu_zone_model mem (.clock, .bus_addr, .bus_wdata, .bus_rd,
      .bus_data_oe, .slow, .bus_rdata, .wr_data, .oe_cycles, .wr_bad);

   // =====================================================
   // clock and hang guard
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 30000) begin
         fail_count++;
         conclude();
      end
   end
   // =====================================================
   // shared helpers
   task automatic conclude();
      if (fail_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask
   // apb transfer, request held until pready is sampled high
   task automatic apb(input logic wr, input logic [25:0] a,
                      input logic [31:0] wd);
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rv = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wreg(input logic [23:0] idx, input logic [15:0] d);
      apb(1'b1, {idx, 2'b00}, {16'h0, d});
   endtask
   task automatic rchk(input logic [23:0] idx, input logic [15:0] e);
      apb(1'b0, {idx, 2'b00}, 32'h0);
      check(rv, {16'h0, e});
      check(err, 1'b0);
   endtask
   // core request; lat counts edges until req_done shows
   task automatic core(input logic wr, input logic [23:0] a,
                       input logic [15:0] d, output int lat);
      lat = 0;
      @(posedge clock);
      req_valid <= 1'b1;
      req_write <= wr;
      req_addr  <= a;
      req_wdata <= d;
      do begin
         @(posedge clock);
         lat++;
         #1;
      end while (req_done !== 1'b1 && lat < 40);
      @(posedge clock);
      req_valid <= 1'b0;
   endtask
   task automatic rd(input logic [23:0] a, input logic [3:0] s,
                     input int e);
      int lat;
      slow <= s;
      core(1'b0, a, 16'h0, lat);
      check(lat, e);
      check(req_rdata, a[15:0] ^ 16'h5A3C);
   endtask
   // =====================================================
   // scenarios
   task automatic t_boot();
      logic [10:0] c [7] = '{11'b111_111_0_0001, 11'b111_111_1_1000,
         11'b011_111_0_0010, 11'b011_111_1_1000, 11'b110_111_1_1000,
         11'b000_111_1_0100, 11'b000_000_0_0001};
      int lat;
      foreach (c[i]) begin
         @(posedge clock);
         rst_n            <= 1'b0;
         boot_config_pins <= c[i][10:8];
         boot_pins_driven <= c[i][7:5];
         flash_empty      <= c[i][4];
         repeat (8) @(posedge clock);
         rst_n <= 1'b1;
         repeat (3) @(posedge clock);
         check({in_system_programming_mode, offchip_program_mode,
                external_code_mode, internal_code_mode},
               c[i][3:0]);
         core(1'b0, 24'h000040, 16'h0, lat);
         check(bus_external, c[i][2]);
      end
   endtask
   task automatic t_regs();
      rchk(IDX_BUS_WRITE_TIMING_CONFIG, 16'h0007);
      rchk(IDX_IO_ZONE_TIMING_CONFIG, 16'h069F);
      rchk(IDX_SZ0, 16'h069F);
      rchk(IDX_SZ1, 16'h069F);
      rchk(IDX_SZ2, 16'h069F);
      apb(1'b0, {24'hFFF90C, 2'b00}, 32'h0);
      check(err, 1'b1);
      apb(1'b1, {IDX_BUS_WRITE_TIMING_CONFIG, 2'b10}, 32'h0);
      check(err, 1'b1);
      wreg(IDX_IO_ZONE_TIMING_CONFIG, 16'hFFFF);
      rchk(IDX_IO_ZONE_TIMING_CONFIG, 16'h069F);
      wreg(IDX_IO_ZONE_TIMING_CONFIG, 16'h0000);
      rchk(IDX_IO_ZONE_TIMING_CONFIG, 16'h0400);
      wreg(IDX_BUS_WRITE_TIMING_CONFIG, 16'h00FF);
      rchk(IDX_BUS_WRITE_TIMING_CONFIG, 16'h0007);
   endtask
   // every wait code, hold codes cycling, slow memory matched to waits
   task automatic t_read();
      int lat;
      wreg(IDX_IO_ZONE_TIMING_CONFIG, 16'h0080);
      core(1'b0, IO_BASE, 16'h0, lat);
      rd(IO_BASE, 4'h1, 3);
      rd(IO_END, 4'h1, 3);
      for (int w = 0; w < 8; w++) begin
         wreg(IDX_IO_ZONE_TIMING_CONFIG, 16'h0080 | (16'(w % 4) << 3) | 16'(w));
         rd(IO_BASE + 24'h4, 4'(w + 1), 3 + w + w % 4);
      end
   endtask
   // fast read ignores large wait and hold values
   task automatic t_fast();
      int lat;
      wreg(IDX_SZ0, 16'h089F);
      core(1'b0, 24'h000100, 16'h0, lat);
      rd(24'h000100, 4'h0, 2);
   endtask
   task automatic t_write();
      int lat;
      wreg(IDX_IO_ZONE_TIMING_CONFIG, 16'h0080);
      core(1'b0, IO_BASE, 16'h0, lat);
      core(1'b1, IO_BASE + 24'h8, 16'hBEEF, lat);
      check(lat, 4);
      wreg(IDX_BUS_WRITE_TIMING_CONFIG, 16'h0006);
      rchk(IDX_BUS_WRITE_TIMING_CONFIG, 16'h0006);
      core(1'b1, IO_BASE + 24'h8, 16'hBEEF, lat);
      check(lat, 3);
      wreg(IDX_IO_ZONE_TIMING_CONFIG, 16'h0090);
      core(1'b1, IO_BASE + 24'hA, 16'h1234, lat);
      check(lat, 5);
      check(bus_addr, IO_BASE + 24'hA);
      repeat (2) @(posedge clock);
      check(oe_cycles, 8'h04);
      check(wr_data, 16'h1234);
      check(wr_bad, 1'b0);
   endtask
   // idle gap after an io cycle only while its post idle bit is set
   task automatic t_idle();
      int l1, l2, lat;
      slow <= 4'h1;
      wreg(IDX_SZ0, 16'h0080);
      wreg(IDX_IO_ZONE_TIMING_CONFIG, 16'h0280);
      core(1'b0, IO_BASE, 16'h0, lat);
      core(1'b0, 24'h000200, 16'h0, l1);
      wreg(IDX_IO_ZONE_TIMING_CONFIG, 16'h0080);
      core(1'b0, IO_BASE, 16'h0, lat);
      check(bus_wide, 1'b1);
      core(1'b0, 24'h000200, 16'h0, l2);
      check(l2, 3);
      check(l1, l2 + 1);
      wreg(IDX_IO_ZONE_TIMING_CONFIG, 16'h0000);
      core(1'b0, IO_BASE, 16'h0, lat);
      check(bus_wide, 1'b0);
   endtask
   // =====================================================
   // main sequence
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 26'h0;
      pwdata = 32'h0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 24'h0;
      req_wdata = 16'h0;
      boot_config_pins = 3'h7;
      boot_pins_driven = 3'h7;
      flash_empty = 1'b0;
      slow = 4'h1;
      fail_count = 0;
      n_tests = 0;
      cycles = 0;
      t_boot();
      t_regs();
      t_read();
      t_fast();
      t_write();
      t_idle();
      conclude();
   end
endmodule

// ---- design/biu_pkg.sv ----
// constants, field layout and state codes of the bus interface unit
// Functional notes
// (RQ1) pins 111 give internal code mode, or programming mode if flash blank
// (RQ2) pins 011 give external code mode, or programming mode if flash blank
// (RQ3) pins 110 always give in-system programming mode
// (RQ4) pins 000 give off-chip mode; flash region goes to the external bus
// (RQ5) mode comes from pins caught at reset plus the flash blank flag
// (RQ6) undriven boot pins read as high
// (RQ7) normal read takes two clocks, fast read one clock
// (RQ8) normal reads are used after reset until fast read is selected
// (RQ9) late write takes two clocks, early write three clocks
// (RQ10) early write is used after reset until software selects late write
// (RQ11) wait cycles follow directly after the address phase
// (RQ12) hold cycles are appended at the end, keeping data driven
// (RQ13) write timing bit 0: 0 late, 1 early; register resets to 07h
// (RQ14) software writes 06h and always sets bits 1 and 2
// (RQ15) io zone settings govern every access in FFFB00h to FFFBFFh
// (RQ16) io wait field adds zero to seven wait cycles
// (RQ17) io hold field adds zero to three hold cycles
// (RQ18) io width bit: 0 eight-bit bus, 1 sixteen-bit bus, default 1
// (RQ19) post idle bit adds one idle cycle when the next zone differs; code inserts ST_GAP but already drives bus_addr, bus_rd and bus_wr in it
// (RQ20) software programs the fewest waits and holds the clock allows
// (RQ21) unit drives bus controls for flash and io zone with zone settings
// (RQ22) fast read takes one clock and ignores wait and hold fields
// (RQ23) reserved bits read as reset value; writes to them do nothing
package biu_pkg;
   // ==========================================================
   // register indices (byte address is four times the index)
   localparam logic [23:0] IDX_BUS_WRITE_TIMING_CONFIG   = 24'hFFF900;
   localparam logic [23:0] IDX_IO_ZONE_TIMING_CONFIG  = 24'hFFF902;
   localparam logic [23:0] IDX_SZ0    = 24'hFFF904;
   localparam logic [23:0] IDX_SZ1    = 24'hFFF906;
   localparam logic [23:0] IDX_SZ2    = 24'hFFF908;
   localparam logic [23:0] IDX_STAT   = 24'hFFF90A;
   // ==========================================================
   // reset values and writable masks
   localparam logic [2:0]  BUS_WRITE_TIMING_CONFIG_RST   = 3'h7;
   localparam logic [15:0] ZONE_RST   = 16'h069F;
   localparam logic [15:0] IO_WMASK   = 16'h029F;
   localparam logic [15:0] SZ_WMASK   = 16'h0EFF;
   // ==========================================================
   // zone config and write timing field positions
   localparam int F_WAIT = 0;
   localparam int F_HOLD = 3;
   localparam int F_BW   = 7;
   localparam int F_POST_IDLE_SELECT = 9;
   localparam int F_FRE  = 11;
   localparam int F_EWR  = 0;
   // ==========================================================
   // address map
   localparam logic [23:0] Z0_END  = 24'h03FFFF;
   localparam logic [23:0] Z1_BASE = 24'h400000;
   localparam logic [23:0] Z2_BASE = 24'h800000;
   localparam logic [23:0] Z2_END  = 24'hFEFFFF;
   localparam logic [23:0] IO_BASE = 24'hFFFB00;
   localparam logic [23:0] IO_END  = 24'hFFFBFF;
   localparam logic [2:0]  ZN_Z0   = 3'h0;
   localparam logic [2:0]  ZN_Z1   = 3'h1;
   localparam logic [2:0]  ZN_Z2   = 3'h2;
   localparam logic [2:0]  ZN_IO   = 3'h3;
   localparam logic [2:0]  ZN_NONE = 3'h4;
   // ==========================================================
   // boot pin codes and one-hot mode bits
   localparam logic [2:0] PIN_IRE = 3'h7;
   localparam logic [2:0] PIN_ERE = 3'h3;
   localparam logic [2:0] PIN_ISP = 3'h6;
   localparam logic [2:0] PIN_DEV = 3'h0;
   localparam int M_INT = 0;
   localparam int M_EXT = 1;
   localparam int M_OFF = 2;
   localparam int M_ISP = 3;
   // ==========================================================
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_GAP  = 7'h02,
      ST_ADDR = 7'h04,
      ST_WAIT = 7'h08,
      ST_DATA = 7'h10,
      ST_LATE = 7'h20,
      ST_HOLD = 7'h40
   } biu_state_type;
endpackage

// ---- design/biu_top.sv ----
// bus interface unit: boot mode, zone bus cycles and apb config registers
`timescale 1ns/100ps
module biu_top
   import biu_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic [2:0]  boot_config_pins,
   input  wire logic [2:0]  boot_pins_driven,
   input  wire logic        flash_empty,
   output logic             internal_code_mode,
   output logic             external_code_mode,
   output logic             offchip_program_mode,
   output logic             in_system_programming_mode,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [25:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        req_valid,
   input  wire logic        req_write,
   input  wire logic [23:0] req_addr,
   input  wire logic [15:0] req_wdata,
   output logic             req_done,
   output logic [15:0]      req_rdata,
   output logic [23:0]      bus_addr,
   output logic [15:0]      bus_wdata,
   output logic             bus_rd,
   output logic             bus_wr,
   output logic             bus_data_oe,
   output logic             bus_wide,
   output logic             bus_external,
   input  wire logic [15:0] bus_rdata
);
   // ==========================================================
   // helpers
   function automatic logic [2:0] zone_of(input logic [23:0] a);
      if (a <= Z0_END)
         return ZN_Z0;
      else if (a >= Z1_BASE && a < Z2_BASE)
         return ZN_Z1;
      else if (a >= Z2_BASE && a <= Z2_END)
         return ZN_Z2;
      else if (a >= IO_BASE && a <= IO_END) // RQ15
         return ZN_IO;
      else
         return ZN_NONE;
   endfunction

   function automatic logic [15:0] merge(input logic [15:0] w,
                                         input logic [15:0] m);
      return (w & m) | (ZONE_RST & ~m); // RQ23
   endfunction

   // ==========================================================
   // boot mode capture
   logic       cap_q;
   logic [3:0] mode_q;
   logic [2:0] pins_eff;

   // floating pins see the internal pull-up
   assign pins_eff = boot_config_pins | ~boot_pins_driven; // RQ6

   // caught once after reset release, never under reset itself
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cap_q  <= 1'b0;
         mode_q <= 4'h0;
      end else if (!cap_q) begin
         cap_q <= 1'b1;
         mode_q <= 4'h0;
         unique case (pins_eff) // RQ5
            PIN_IRE: mode_q[flash_empty ? M_ISP : M_INT] <= 1'b1; // RQ1
            PIN_ERE: mode_q[flash_empty ? M_ISP : M_EXT] <= 1'b1; // RQ2
            PIN_DEV: mode_q[M_OFF] <= 1'b1; // RQ4
            default: mode_q[M_ISP] <= 1'b1; // RQ3
         endcase
      end
   end

   assign internal_code_mode         = mode_q[M_INT];
   assign external_code_mode         = mode_q[M_EXT];
   assign offchip_program_mode       = mode_q[M_OFF];
   assign in_system_programming_mode = mode_q[M_ISP];

   // ==========================================================
   // apb register file
   logic [2:0]  bus_write_timing_config_q;
   logic [15:0] io_q;
   logic [15:0] sz_q [0:2];
   logic [31:0] prdata_q;
   logic        pslverr_q;
   logic [23:0] pidx;
   logic        pok;
   logic        busy;

   assign pidx   = paddr[25:2];
   assign pok    = (paddr[1:0] == 2'h0);
   assign pready = psel & penable;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;

   // writes land only at the access edge
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bus_write_timing_config_q <= BUS_WRITE_TIMING_CONFIG_RST; // RQ13 RQ10
         io_q   <= ZONE_RST; // RQ18
         for (int i = 0; i < 3; i++)
            sz_q[i] <= ZONE_RST; // RQ8
      end else if (psel && penable && pwrite && pok) begin
         if (pidx == IDX_BUS_WRITE_TIMING_CONFIG)
            bus_write_timing_config_q <= pwdata[2:0]; // RQ13
         if (pidx == IDX_IO_ZONE_TIMING_CONFIG)
            io_q <= merge(pwdata[15:0], IO_WMASK); // RQ23
         for (int i = 0; i < 3; i++)
            if (pidx == IDX_SZ0 + 24'(2 * i))
               sz_q[i] <= merge(pwdata[15:0], SZ_WMASK);
      end
   end

   // read data and error prepared in the setup cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prdata_q  <= 32'h0;
         pslverr_q <= 1'b0;
      end else if (psel && !penable) begin
         pslverr_q <= 1'b0;
         if (!pok)
            pslverr_q <= 1'b1;
         else if (pidx == IDX_BUS_WRITE_TIMING_CONFIG)
            prdata_q <= {29'h0, bus_write_timing_config_q};
         else if (pidx == IDX_IO_ZONE_TIMING_CONFIG)
            prdata_q <= {16'h0, io_q};
         else if (pidx == IDX_SZ0)
            prdata_q <= {16'h0, sz_q[0]};
         else if (pidx == IDX_SZ1)
            prdata_q <= {16'h0, sz_q[1]};
         else if (pidx == IDX_SZ2)
            prdata_q <= {16'h0, sz_q[2]};
         else if (pidx == IDX_STAT)
            prdata_q <= {27'h0, busy, mode_q};
         else
            pslverr_q <= 1'b1;
      end
   end

   // ==========================================================
   // bus cycle sequencer
   biu_state_type st_q;
   logic [2:0]  cnt_q;
   logic [2:0]  wait_q;
   logic [1:0]  hold_q;
   logic        fast_q;
   logic        early_q;
   logic        wr_q;
   logic [2:0]  zone_q;
   logic [2:0]  last_q;
   logic        post_idle_select_q;
   logic        pend_q;
   logic        done_q;
   logic [2:0]  zone_d;
   logic [15:0] cfg_d;
   logic        take;
   logic        fin;

   assign zone_d = zone_of(req_addr);
   assign take   = (st_q == ST_IDLE) && req_valid && !done_q;
   assign busy   = (st_q != ST_IDLE);

   // settings of the addressed zone; unmapped space runs bare
   always_comb begin
      unique case (zone_d) // RQ21
         ZN_Z0:   cfg_d = sz_q[0];
         ZN_Z1:   cfg_d = sz_q[1];
         ZN_Z2:   cfg_d = sz_q[2];
         ZN_IO:   cfg_d = io_q; // RQ15
         default: cfg_d = 16'h0080;
      endcase
   end

   // last clock of the cycle; idle gap does not count as part of it
   always_comb begin
      fin = 1'b0;
      unique case (st_q)
         ST_ADDR: fin = fast_q; // RQ22
         ST_DATA: fin = !(wr_q && early_q) && hold_q == 2'h0;
         ST_LATE: fin = hold_q == 2'h0;
         ST_HOLD: fin = cnt_q == 3'h0;
         default: fin = 1'b0;
      endcase
   end

   // state walk: addr, waits, data, early-write tail, holds
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_q  <= ST_IDLE;
         cnt_q <= 3'h0;
      end else begin
         unique case (st_q)
            ST_IDLE:
               if (take)
                  st_q <= (pend_q && zone_d != last_q) ? ST_GAP // RQ19
                                                       : ST_ADDR;
            ST_GAP:
               st_q <= ST_ADDR;
            ST_ADDR:
               if (fast_q)
                  st_q <= ST_IDLE; // RQ7 RQ22
               else if (wait_q != 3'h0) begin
                  st_q  <= ST_WAIT; // RQ11 RQ16
                  cnt_q <= wait_q - 3'h1;
               end else
                  st_q <= ST_DATA;
            ST_WAIT:
               if (cnt_q == 3'h0)
                  st_q <= ST_DATA;
               else
                  cnt_q <= cnt_q - 3'h1;
            ST_DATA:
               if (wr_q && early_q)
                  st_q <= ST_LATE; // RQ9
               else if (hold_q != 2'h0) begin
                  st_q  <= ST_HOLD; // RQ12 RQ17
                  cnt_q <= {1'b0, hold_q} - 3'h1;
               end else
                  st_q <= ST_IDLE;
            ST_LATE:
               if (hold_q != 2'h0) begin
                  st_q  <= ST_HOLD;
                  cnt_q <= {1'b0, hold_q} - 3'h1;
               end else
                  st_q <= ST_IDLE;
            ST_HOLD:
               if (cnt_q == 3'h0)
                  st_q <= ST_IDLE;
               else
                  cnt_q <= cnt_q - 3'h1;
         endcase
      end
   end

   // per-access settings latched when the request is taken
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wait_q  <= 3'h0;
         hold_q  <= 2'h0;
         fast_q  <= 1'b0;
         early_q <= 1'b1;
         wr_q    <= 1'b0;
         zone_q  <= ZN_NONE;
         post_idle_select_q  <= 1'b0;
      end else if (take) begin
         fast_q  <= !req_write && cfg_d[F_FRE]; // RQ8 RQ22
         wait_q  <= cfg_d[F_WAIT +: 3];
         hold_q  <= cfg_d[F_HOLD +: 2];
         early_q <= bus_write_timing_config_q[F_EWR]; // RQ13
         wr_q    <= req_write;
         zone_q  <= zone_d;
         post_idle_select_q  <= cfg_d[F_POST_IDLE_SELECT];
      end
   end

   // post idle bookkeeping and the completion pulse
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= 1'b0;
         last_q <= ZN_NONE;
         done_q <= 1'b0;
      end else begin
         done_q <= fin;
         if (fin) begin
            pend_q <= post_idle_select_q; // RQ19
            last_q <= zone_q;
         end
      end
   end

   // bus pins; data stays driven through hold cycles
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bus_addr     <= 24'h0;
         bus_wdata    <= 16'h0;
         bus_rd       <= 1'b0;
         bus_wr       <= 1'b0;
         bus_data_oe  <= 1'b0;
         bus_wide     <= 1'b1;
         bus_external <= 1'b0;
      end else if (take) begin
         bus_addr  <= req_addr; // RQ21
         bus_wdata <= req_wdata;
         bus_rd    <= !req_write;
         bus_wr    <= req_write;
         bus_data_oe <= req_write; // RQ12
         bus_wide  <= cfg_d[F_BW]; // RQ18
         bus_external <= zone_d == ZN_Z1 || zone_d == ZN_Z2
            || (zone_d == ZN_Z0 && mode_q[M_OFF]); // RQ4
      end else if (fin) begin
         bus_rd      <= 1'b0;
         bus_wr      <= 1'b0;
         bus_data_oe <= 1'b0;
      end
   end

   // read data sampled at the data clock, or the address clock if fast
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         req_rdata <= 16'h0;
      else if (!wr_q && ((st_q == ST_DATA) ||
                         (st_q == ST_ADDR && fast_q)))
         req_rdata <= bus_rdata;
   end

   assign req_done = done_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_mode_onehot: assert property (cap_q |-> $onehot(mode_q)) // RQ5
      else $error("boot mode not one-hot");
   a_isp_forced: assert property (!cap_q && pins_eff == PIN_ISP
      |=> mode_q[M_ISP]) // RQ3
      else $error("pins 110 did not give programming mode");
   a_blank_isp: assert property (!cap_q && pins_eff == PIN_IRE
      && flash_empty |=> mode_q[M_ISP]) // RQ1
      else $error("blank flash did not force programming mode");
   a_fast_read: assert property (st_q == ST_ADDR && fast_q
      |=> st_q == ST_IDLE && done_q) // RQ22
      else $error("fast read not one clock");
   a_normal_read: assert property (st_q == ST_ADDR && !fast_q && !wr_q
      && wait_q == 3'h0 && hold_q == 2'h0
      |=> st_q == ST_DATA ##1 done_q) // RQ7
      else $error("normal read not two clocks");
   a_late_write: assert property (st_q == ST_ADDR && wr_q && !early_q
      && wait_q == 3'h0 && hold_q == 2'h0
      |=> st_q == ST_DATA ##1 done_q) // RQ9
      else $error("late write not two clocks");
   a_early_write: assert property (st_q == ST_ADDR && wr_q && early_q
      && wait_q == 3'h0 && hold_q == 2'h0
      |=> st_q == ST_DATA ##1 st_q == ST_LATE ##1 done_q) // RQ9
      else $error("early write not three clocks");
   a_wait_seven: assert property (st_q == ST_ADDR && !fast_q
      && wait_q == 3'h7
      |=> (st_q == ST_WAIT) [*7] ##1 st_q == ST_DATA) // RQ11
      else $error("seven waits not inserted");
   a_hold_three: assert property (st_q == ST_DATA && !wr_q
      && hold_q == 2'h3 |=> (st_q == ST_HOLD && bus_rd) [*3]
      ##1 done_q) // RQ12
      else $error("three holds not appended");
   a_io_zone: assert property (take && req_addr >= IO_BASE
      && req_addr <= IO_END |=> zone_q == ZN_IO
      && wait_q == io_q[F_WAIT +: 3]) // RQ15
      else $error("io zone settings not applied");
   a_post_idle: assert property (take && pend_q && zone_d != last_q
      |=> st_q == ST_GAP ##1 st_q == ST_ADDR) // RQ19
      else $error("post idle gap missing");
   a_bus_write_timing_config_reset: assert property (!cap_q |-> bus_write_timing_config_q == BUS_WRITE_TIMING_CONFIG_RST) // RQ10
      else $error("write timing reset value wrong");

   // a completion is one clock only, so the core cannot count it twice
   a_done_single: assert property (done_q |=> !done_q) // RQ21
      else $error("completion pulse longer than one clock");
   // write data must stay on the pins through every hold clock
   a_hold_data: assert property (bus_data_oe && st_q == ST_HOLD
      |-> $stable(bus_wdata)) // RQ12
      else $error("write data moved during hold");
   // floating pins must never be taken as low levels
   a_float_high: assert property (!cap_q && boot_pins_driven == 3'h0
      |=> mode_q[M_INT] || mode_q[M_ISP]) // RQ6
      else $error("floating boot pins not read high");

   // main scenarios that the bench is expected to reach
   c_fast_read: cover property (st_q == ST_ADDR && fast_q);
   c_hold: cover property (st_q == ST_HOLD);
   c_early_write: cover property (st_q == ST_LATE);
   c_gap: cover property (st_q == ST_GAP);
   c_isp: cover property (mode_q[M_ISP]);
endmodule
